// [l3_uncore_event_counter_bank_tb_top.sv]
// Self-checking testbench for the uncore event counter bank
`timescale 1ns/100ps
`default_nettype none
module l3_uncore_event_counter_bank_tb_top
  import ucb_pkg::*;
;
  // Clock, reset and design ports
  logic                                   mclk;
  logic                                   rst_n;
  logic                                   mreg_req;
  logic                                   mreg_we;
  logic [31:0]                            mreg_addr;
  logic [63:0]                            mreg_wdata;
  logic                                   mreg_ack;
  logic                                   mreg_fault;
  logic [63:0]                            mreg_rdata;
  logic                                   ctr_rd_req;
  logic [31:0]                            ctr_rd_index;
  logic                                   ctr_rd_ack;
  logic                                   ctr_rd_fault;
  logic [31:0]                            ctr_rd_upper;
  logic [31:0]                            ctr_rd_lower;
  logic [UCB_NUM_EVT-1:0]                 evt_inc;
  logic                                   lat_valid;
  logic [15:0]                            lat_weight;
  logic [UCB_NUM_EVT-1:0][UCB_HALF_W-1:0] evt_qual;
  logic                                   lat_en;
  // Bench bookkeeping
  int                                     n_errors;
  int                                     checks_done;
  int                                     cycles;
  logic [31:0]                            exp_lo [8];
  logic [31:0]                            qual   [6];

  ucb_counter_bank #(.LAT_W(16)) u_ucb_counter_bank (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .mreg_req     (mreg_req),
    .mreg_we      (mreg_we),
    .mreg_addr    (mreg_addr),
    .mreg_wdata   (mreg_wdata),
    .mreg_ack     (mreg_ack),
    .mreg_fault   (mreg_fault),
    .mreg_rdata   (mreg_rdata),
    .ctr_rd_req   (ctr_rd_req),
    .ctr_rd_index (ctr_rd_index),
    .ctr_rd_ack   (ctr_rd_ack),
    .ctr_rd_fault (ctr_rd_fault),
    .ctr_rd_upper (ctr_rd_upper),
    .ctr_rd_lower (ctr_rd_lower),
    .evt_inc      (evt_inc),
    .lat_valid    (lat_valid),
    .lat_weight   (lat_weight),
    .evt_qual     (evt_qual),
    .lat_en       (lat_en)
  );

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // One model register access; answer sampled while the ack stands
  task automatic mreg(input logic we, input logic [31:0] addr, input logic [63:0] wd);
    @(negedge mclk);
    mreg_req   = 1'b1;
    mreg_we    = we;
    mreg_addr  = addr;
    mreg_wdata = wd;
    @(negedge mclk);
    check("mreg_ack", {63'h0, mreg_ack}, 64'h1);
    mreg_req = 1'b0;
  endtask

  // Read a register and compare data and fault flag
  task automatic rd_chk(input logic [31:0] addr, input logic [63:0] exp, input logic flt);
    mreg(1'b0, addr, 64'h0);
    check("mreg_rdata", mreg_rdata, exp);
    check("mreg_fault", {63'h0, mreg_fault}, {63'h0, flt});
  endtask

  // One counter read instruction with expected lower word and fault
  task automatic ctr_chk(input logic [31:0] idx, input logic [31:0] exp, input logic flt);
    @(negedge mclk);
    ctr_rd_req   = 1'b1;
    ctr_rd_index = idx;
    @(negedge mclk);
    ctr_rd_req = 1'b0;
    check("ctr_rd_ack", {63'h0, ctr_rd_ack}, 64'h1);
    check("ctr_rd_upper", {32'h0, ctr_rd_upper}, 64'h0);
    check("ctr_rd_lower", {32'h0, ctr_rd_lower}, {32'h0, exp});
    check("ctr_rd_fault", {63'h0, ctr_rd_fault}, {63'h0, flt});
  endtask

  // Raise event inputs for n counting edges
  task automatic pulse(input logic [UCB_NUM_EVT-1:0] mask, input int n);
    evt_inc = mask;
    repeat (n) @(negedge mclk);
    evt_inc = '0;
  endtask

  // Present a latency weight for n edges
  task automatic feed(input logic [15:0] w, input int n);
    lat_valid  = 1'b1;
    lat_weight = w;
    repeat (n) @(negedge mclk);
    lat_valid = 1'b0;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    mreg_req = 1'b0;
    mreg_we = 1'b0;
    mreg_addr = 32'h0;
    mreg_wdata = 64'h0;
    ctr_rd_req = 1'b0;
    ctr_rd_index = 32'h0;
    evt_inc = '0;
    lat_valid = 1'b0;
    lat_weight = 16'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    // Reset values and unmapped neighbours of the window
    for (int k = 0; k < 8; k++) begin
      rd_chk(UCB_ADDR_BUS_Q0 + k, UCB_REG_RST, 1'b0);
    end
    mreg(1'b1, 32'h0001_07CB, 64'hFFFF_FFFF_FFFF_FFFF);
    rd_chk(32'h0001_07CB, 64'h0, 1'b1);
    rd_chk(32'h0001_07D4, 64'h0, 1'b1);
    rd_chk(UCB_ADDR_BUS_Q0, 64'h0, 1'b0);
    // Zero qualification keeps every event counter idle
    for (int k = 0; k < 6; k++) begin
      exp_lo[k] = 32'h0000_0100 * k + 32'h5;
      qual[k] = (k == 5) ? 32'h8000_0000 : (32'h1 << (k * 6));
      mreg(1'b1, UCB_ADDR_BUS_Q0 + k, {32'h0, exp_lo[k]});
    end
    pulse(6'h3F, 6);
    for (int k = 0; k < 6; k++) begin
      rd_chk(UCB_ADDR_BUS_Q0 + k, {32'h0, exp_lo[k]}, 1'b0);
    end
    // Non-zero qualification starts counting, per register mapping
    for (int k = 0; k < 6; k++) begin
      mreg(1'b1, UCB_ADDR_BUS_Q0 + k, {qual[k], exp_lo[k]});
    end
    pulse(6'h3F, 6);
    pulse(6'h15, 3);
    for (int k = 0; k < 6; k++) begin
      exp_lo[k] = exp_lo[k] + 32'h6 + ((k % 2 == 0) ? 32'h3 : 32'h0);
      rd_chk(UCB_ADDR_BUS_Q0 + k, {qual[k], exp_lo[k]}, 1'b0);
      check("evt_qual", {32'h0, evt_qual[k]}, {32'h0, qual[k]});
    end
    // Event counter wraps past its maximum
    mreg(1'b1, UCB_ADDR_BUS_Q0, {32'h0000_0001, 32'hFFFF_FFFE});
    pulse(6'h01, 3);
    exp_lo[0] = 32'h1;
    rd_chk(UCB_ADDR_BUS_Q0, 64'h0000_0001_0000_0001, 1'b0);
    // Neighbouring control bit does not enable accumulation
    mreg(1'b1, UCB_ADDR_LAT_CTL, 64'h0000_0000_0200_0000);
    check("lat_en", {63'h0, lat_en}, 64'h0);
    feed(16'h0005, 4);
    rd_chk(UCB_ADDR_LAT_ACC, 64'h0, 1'b0);
    // Bit 26 enables weighted accumulation
    mreg(1'b1, UCB_ADDR_LAT_CTL, 64'h0000_0000_0400_0000);
    check("lat_en", {63'h0, lat_en}, 64'h1);
    feed(16'hFFFF, 3);
    rd_chk(UCB_ADDR_LAT_ACC, 64'h0000_0000_0002_FFFD, 1'b0);
    // Clearing bit 26 freezes the accumulator
    mreg(1'b1, UCB_ADDR_LAT_CTL, 64'h0);
    check("lat_en", {63'h0, lat_en}, 64'h0);
    feed(16'h0007, 4);
    rd_chk(UCB_ADDR_LAT_ACC, 64'h0000_0000_0002_FFFD, 1'b0);
    // Accumulator wraps modulo two to the sixty-fourth
    mreg(1'b1, UCB_ADDR_LAT_ACC, 64'hFFFF_FFFF_FFFF_FFF0);
    mreg(1'b1, UCB_ADDR_LAT_CTL, 64'hA5A5_0000_0400_0000);
    feed(16'h0020, 1);
    rd_chk(UCB_ADDR_LAT_ACC, 64'h0000_0000_0000_0010, 1'b0);
    rd_chk(UCB_ADDR_LAT_CTL, 64'hA5A5_0000_0400_0000, 1'b0);
    exp_lo[6] = 32'h0400_0000;
    exp_lo[7] = 32'h0000_0010;
    // Counter read indices in address order, and refused indices
    mreg(1'b1, UCB_ADDR_LAT_CTL, 64'hA5A5_0000_0000_0000);
    exp_lo[6] = 32'h0;
    // Back-to-back write then read sees the new qualification half
    @(negedge mclk);
    mreg_req   = 1'b1;
    mreg_we    = 1'b1;
    mreg_addr  = UCB_ADDR_SNP_Q1;
    mreg_wdata = {32'h0000_0C00, exp_lo[3]};
    @(negedge mclk);
    mreg_we = 1'b0;
    @(negedge mclk);
    mreg_req = 1'b0;
    check("mreg_ack", {63'h0, mreg_ack}, 64'h1);
    check("mreg_rdata", mreg_rdata, {32'h0000_0C00, exp_lo[3]});
    for (int k = 0; k < 8; k++) begin
      ctr_chk(UCB_CTR_IDX_FIRST + k, exp_lo[k], 1'b0);
    end
    ctr_chk(32'h0000_0011, 32'h0, 1'b1);
    ctr_chk(32'h0000_001A, 32'h0, 1'b1);
    ctr_chk(32'h0001_0012, 32'h0, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire

// [ucb_counter_bank.sv]
// Uncore event counter bank: register access, counter read port, checks
//
// Summary of operation
// - Low 32 bits of all eight registers read as 32-bit performance counters.
// - Counter read indices 18 to 25 select the registers in address order.
// - Counter read returns zero upper result and the 32-bit count lower.
// - Two bus queue event registers at 107CC and 107CD count queue conditions.
// - Bus queue registers: upper half qualifies, lower half counts.
// - Bus queue counter idles until an upper bit is non-zero.
// - Two snoop queue registers at 107CE and 107CF, same split.
// - Snoop queue counter counts only once an upper bit is non-zero.
// - Two external bus ready registers at 107D0 and 107D1 count bus conditions.
// - External bus counter starts once an upper qualification bit is set.
// - Writing 1 to latency control bit 26 enables latency accumulation.
// - Clearing bit 26 freezes the latency accumulator at its value.
// - Latency accumulator at 107D3 adds weighted cycles as 64-bit counter.
`timescale 1ns/100ps
`default_nettype none
module ucb_counter_bank
  import ucb_pkg::*;
#(
  parameter int unsigned LAT_W = 16
) (
  // Clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 rst_n,
  // Model register read and write port
  input  wire logic                                 mreg_req,
  input  wire logic                                 mreg_we,
  input  wire logic [31:0]                          mreg_addr,
  input  wire logic [63:0]                          mreg_wdata,
  output logic                                      mreg_ack,
  output logic                                      mreg_fault,
  output logic [63:0]                               mreg_rdata,
  // Counter read instruction port
  input  wire logic                                 ctr_rd_req,
  input  wire logic [31:0]                          ctr_rd_index,
  output logic                                      ctr_rd_ack,
  output logic                                      ctr_rd_fault,
  output logic [31:0]                               ctr_rd_upper,
  output logic [31:0]                               ctr_rd_lower,
  // Event sources
  input  wire logic [UCB_NUM_EVT-1:0]               evt_inc,
  input  wire logic                                 lat_valid,
  input  wire logic [LAT_W-1:0]                     lat_weight,
  // Qualification fields to the event logic
  output logic [UCB_NUM_EVT-1:0][UCB_HALF_W-1:0]    evt_qual,
  output logic                                      lat_en
);

  typedef struct packed {
    logic        mreg_ack;
    logic        mreg_fault;
    logic [63:0] mreg_rdata;
    logic        ctr_ack;
    logic        ctr_fault;
    logic [31:0] ctr_upper;
    logic [31:0] ctr_lower;
  } ucb_top_state_t;

  ucb_top_state_t state_r;
  ucb_top_state_t state_nxt;

  logic [63:0]             reg_val [UCB_NUM_REGS];
  logic [UCB_NUM_REGS-1:0] wr_stb;
  logic [2:0]              mreg_idx;
  logic                    mreg_hit;
  logic [31:0]             ctr_off;
  logic                    ctr_hit;
  logic [2:0]              ctr_idx;

  ucb_reg_if rif [UCB_NUM_REGS] ();

  // Address decode of the eight registers
  always_comb begin
    mreg_hit = 1'b1;
    mreg_idx = 3'h0;
    unique case (mreg_addr)
      UCB_ADDR_BUS_Q0:  mreg_idx = 3'h0;
      UCB_ADDR_BUS_Q1:  mreg_idx = 3'h1;
      UCB_ADDR_SNP_Q0:  mreg_idx = 3'h2;
      UCB_ADDR_SNP_Q1:  mreg_idx = 3'h3;
      UCB_ADDR_EXT_RD0: mreg_idx = 3'h4;
      UCB_ADDR_EXT_RD1: mreg_idx = 3'h5;
      UCB_ADDR_LAT_CTL: mreg_idx = 3'h6;
      UCB_ADDR_LAT_ACC: mreg_idx = 3'h7;
      default: begin
        mreg_hit = 1'b0;
        mreg_idx = 3'h0;
      end
    endcase
  end

  // Counter index window, mapped in address order
  assign ctr_off = ctr_rd_index - UCB_CTR_IDX_FIRST;
  assign ctr_hit = (ctr_rd_index >= UCB_CTR_IDX_FIRST) && (ctr_rd_index <= UCB_CTR_IDX_LAST);
  assign ctr_idx = ctr_off[2:0];

  // Per-register strobes and value taps
  genvar gi;
  generate
    for (gi = 0; gi < UCB_NUM_REGS; gi++) begin : g_reg
      assign rif[gi].wr    = mreg_req && mreg_we && mreg_hit && (mreg_idx == 3'(gi));
      assign rif[gi].wdata = mreg_wdata;
      assign reg_val[gi]   = rif[gi].value;
      assign wr_stb[gi]    = rif[gi].wr;
    end
    for (gi = 0; gi < UCB_NUM_EVT; gi++) begin : g_evt
      ucb_event_reg u_evt (
        .mclk  (mclk),
        .rst_n (rst_n),
        .inc   (evt_inc[gi]),
        .rif   (rif[gi])
      );
      assign evt_qual[gi] = reg_val[gi][63:UCB_QUAL_LSB];
    end
  endgenerate

  ucb_latency #(
    .LAT_W (LAT_W)
  ) u_lat (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .lat_valid  (lat_valid),
    .lat_weight (lat_weight),
    .ctl_if     (rif[UCB_IDX_LAT_CTL]),
    .acc_if     (rif[UCB_IDX_LAT_ACC]),
    .lat_en     (lat_en)
  );

  // Answers of both ports, registered one cycle after the request
  always_comb begin
    state_nxt           = state_r;
    state_nxt.mreg_ack  = mreg_req;
    state_nxt.ctr_ack   = ctr_rd_req;
    state_nxt.ctr_upper = 32'h0000_0000;
    if (mreg_req) begin
      state_nxt.mreg_fault = !mreg_hit;
      state_nxt.mreg_rdata = 64'h0000_0000_0000_0000;
      if (!mreg_we && mreg_hit) begin
        state_nxt.mreg_rdata = reg_val[mreg_idx];
      end
    end
    if (ctr_rd_req) begin
      state_nxt.ctr_fault = !ctr_hit;
      state_nxt.ctr_lower = 32'h0000_0000;
      if (ctr_hit) begin
        state_nxt.ctr_lower = reg_val[ctr_idx][31:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Port views of the state
  assign mreg_ack     = state_r.mreg_ack;
  assign mreg_fault   = state_r.mreg_fault;
  assign mreg_rdata   = state_r.mreg_rdata;
  assign ctr_rd_ack   = state_r.ctr_ack;
  assign ctr_rd_fault = state_r.ctr_fault;
  assign ctr_rd_upper = state_r.ctr_upper;
  assign ctr_rd_lower = state_r.ctr_lower;

  // Checks, all on mclk
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic [63:0] lat_weight_ext;
  assign lat_weight_ext = {{(64-LAT_W){1'b0}}, lat_weight};

  property p_wr_readback;
    logic [31:0] q;
    (mreg_req && mreg_we && mreg_hit, q = mreg_wdata[63:32])
      ##1 (mreg_req && !mreg_we && (mreg_addr == $past(mreg_addr)))
      |=> (mreg_rdata[63:32] == q) && mreg_ack;
  endproperty

  a_mreg_answer: assert property (
    mreg_req |=> mreg_ack ##0 (mreg_fault == !$past(mreg_hit))
  ) else $error("register access not answered one cycle later");

  a_unmapped_read: assert property (
    mreg_req && !mreg_hit |=> mreg_fault && (mreg_rdata == 64'h0000_0000_0000_0000)
  ) else $error("unmapped access did not fault with zero data");

  a_qual_readback: assert property (p_wr_readback)
    else $error("qualification half not read back as written");

  a_ctr_first_idx: assert property (
    ctr_rd_req && (ctr_rd_index == UCB_CTR_IDX_FIRST)
      |=> ctr_rd_ack && (ctr_rd_lower == $past(reg_val[0][31:0]))
  ) else $error("first counter index does not map to first register");

  a_ctr_last_idx: assert property (
    ctr_rd_req && (ctr_rd_index == UCB_CTR_IDX_LAST)
      |=> !ctr_rd_fault && (ctr_rd_lower == $past(reg_val[UCB_IDX_LAT_ACC][31:0]))
  ) else $error("last counter index does not return accumulator low word");

  a_upper_zero: assert property (
    ctr_rd_ack |-> (ctr_rd_upper == 32'h0000_0000)
  ) else $error("counter read upper result not zero");

  a_ctr_out_range: assert property (
    ctr_rd_req && !ctr_hit |=> ctr_rd_fault && (ctr_rd_lower == 32'h0000_0000)
  ) else $error("out of range counter index not refused");

  a_bus_q_idle: assert property (
    !wr_stb[0] && (reg_val[0][63:32] == 32'h0000_0000)
      |=> $stable(reg_val[0][31:0])
  ) else $error("bus queue counter moved with zero qualification");

  a_bus_q_count: assert property (
    !wr_stb[1] && (|reg_val[1][63:32]) && evt_inc[1]
      |=> reg_val[1][31:0] == $past(reg_val[1][31:0]) + 32'h0000_0001
  ) else $error("bus queue counter missed an event");

  a_snoop_idle: assert property (
    (!wr_stb[2] && (reg_val[2][63:32] == 32'h0000_0000))[*2]
      |-> $stable(reg_val[2][31:0])
  ) else $error("snoop queue counter moved with zero qualification");

  a_snoop_count: assert property (
    !wr_stb[3] && (|reg_val[3][63:32]) && evt_inc[3]
      |=> reg_val[3][31:0] != $past(reg_val[3][31:0])
  ) else $error("snoop queue counter missed an event");

  a_ext_idle: assert property (
    !wr_stb[4] && (reg_val[4][63:32] == 32'h0000_0000) && evt_inc[4]
      |=> reg_val[4] == $past(reg_val[4])
  ) else $error("external bus counter moved with zero qualification");

  a_ext_count: assert property (
    !wr_stb[4] && (|reg_val[4][63:32]) && !evt_inc[4]
      |=> reg_val[4][31:0] == $past(reg_val[4][31:0])
  ) else $error("external bus counter moved without an event");

  a_evt_wrap: assert property (
    !wr_stb[5] && (|reg_val[5][63:32]) && evt_inc[5]
      && (reg_val[5][31:0] == 32'hFFFF_FFFF)
      |=> (reg_val[5][31:0] == 32'h0000_0000) && $stable(reg_val[5][63:32])
  ) else $error("event counter did not wrap to zero");

  a_lat_enable: assert property (
    mreg_req && mreg_we && (mreg_addr == UCB_ADDR_LAT_CTL)
      |=> lat_en == $past(mreg_wdata[UCB_LAT_EN_BIT])
  ) else $error("latency enable does not follow control bit");

  a_lat_accum: assert property (
    lat_en && lat_valid && !wr_stb[UCB_IDX_LAT_ACC]
      |=> reg_val[UCB_IDX_LAT_ACC]
          == $past(reg_val[UCB_IDX_LAT_ACC]) + $past(lat_weight_ext)
  ) else $error("latency accumulator did not add the weight");

  a_lat_freeze: assert property (
    !lat_en && !wr_stb[UCB_IDX_LAT_ACC] |=> $stable(reg_val[UCB_IDX_LAT_ACC])
  ) else $error("latency accumulator moved while frozen");

  a_read_data_match: assert property (
    mreg_req && !mreg_we && mreg_hit
      |=> !mreg_fault && (mreg_rdata == $past(reg_val[mreg_idx]))
  ) else $error("register read did not return the held value");

  a_write_data_zero: assert property (
    mreg_req && mreg_we |=> mreg_rdata == 64'h0000_0000_0000_0000
  ) else $error("write answer carried non-zero data");

  a_ack_needs_req: assert property (
    !mreg_req |=> !mreg_ack
  ) else $error("register answer without a request");

  a_ctr_ack_req: assert property (
    !ctr_rd_req |=> !ctr_rd_ack
  ) else $error("counter read answer without a request");

  a_ctr_in_range: assert property (
    ctr_rd_req && ctr_hit
      |=> ctr_rd_ack && !ctr_rd_fault && (ctr_rd_lower == $past(reg_val[ctr_idx][31:0]))
  ) else $error("in range counter read returned the wrong word");

  a_ctr_snoop_idx: assert property (
    ctr_rd_req && (ctr_rd_index == UCB_CTR_IDX_FIRST + 32'h0000_0003)
      |=> ctr_rd_lower == $past(reg_val[3][31:0])
  ) else $error("fourth counter index does not map to fourth register");

  a_event_write_load: assert property (
    wr_stb[0] |=> reg_val[0] == $past(mreg_wdata)
  ) else $error("event register write not loaded whole");

  a_acc_write_load: assert property (
    wr_stb[UCB_IDX_LAT_ACC] |=> reg_val[UCB_IDX_LAT_ACC] == $past(mreg_wdata)
  ) else $error("accumulator write not loaded whole");

  a_bus_one_idle: assert property (
    !wr_stb[1] && (reg_val[1][63:32] == 32'h0000_0000)
      |=> $stable(reg_val[1][31:0])
  ) else $error("second bus queue counter moved with zero qualification");

  a_snoop_two_count: assert property (
    !wr_stb[2] && (|reg_val[2][63:32]) && evt_inc[2]
      |=> reg_val[2][31:0] == $past(reg_val[2][31:0]) + 32'h0000_0001
  ) else $error("snoop queue counter did not step by one");

  a_ext_five_count: assert property (
    !wr_stb[5] && (|reg_val[5][63:32]) && evt_inc[5]
      |=> reg_val[5][31:0] == $past(reg_val[5][31:0]) + 32'h0000_0001
  ) else $error("external bus counter did not step by one");

  a_lat_ctl_hold: assert property (
    !wr_stb[UCB_IDX_LAT_CTL] |=> $stable(lat_en)
  ) else $error("latency enable changed without a control write");

  // Main scenarios
  c_evt_wrap: cover property (
    evt_inc[0] && (reg_val[0][31:0] == 32'hFFFF_FFFF) && (|reg_val[0][63:32])
  );

  c_lat_run: cover property (
    lat_en && lat_valid ##1 lat_en && lat_valid ##1 !lat_en
  );

  c_ctr_read: cover property (
    ctr_rd_req && ctr_hit ##1 ctr_rd_ack && (ctr_rd_lower != 32'h0000_0000)
  );

  c_unmapped: cover property (
    mreg_req && !mreg_hit ##1 mreg_fault
  );

  c_ctr_refused: cover property (
    ctr_rd_req && !ctr_hit ##1 ctr_rd_fault
  );

endmodule
`default_nettype wire

// [ucb_event_reg.sv]
// One event register: qualification half and 32-bit counter half
`timescale 1ns/100ps
`default_nettype none
module ucb_event_reg
  import ucb_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Event occurrence from the qualifying logic
  input  wire logic inc,
  // Register access
  ucb_reg_if.bank   rif
);

  typedef struct packed {
    logic [31:0] qual;
    logic [31:0] count;
  } ucb_evt_state_t;

  ucb_evt_state_t state_r;
  ucb_evt_state_t state_nxt;

  // Full 64-bit write wins; otherwise count while any qualification bit is set
  always_comb begin
    state_nxt = state_r;
    if (rif.wr) begin
      state_nxt = ucb_evt_state_t'(rif.wdata);
    end else if ((|state_r.qual) && inc) begin
      state_nxt.count = state_r.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ucb_evt_state_t'(UCB_REG_RST);
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rif.value = state_r;

endmodule
`default_nettype wire

// [ucb_latency.sv]
// Latency control register and 64-bit weighted latency accumulator
`timescale 1ns/100ps
`default_nettype none
module ucb_latency
  import ucb_pkg::*;
#(
  parameter int unsigned LAT_W = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Weighted latency samples
  input  wire logic             lat_valid,
  input  wire logic [LAT_W-1:0] lat_weight,
  // Register access
  ucb_reg_if.bank               ctl_if,
  ucb_reg_if.bank               acc_if,
  // Enable seen by the queue logic
  output logic                  lat_en
);

  typedef struct packed {
    logic [63:0] ctl;
    logic [63:0] acc;
  } ucb_lat_state_t;

  ucb_lat_state_t state_r;
  ucb_lat_state_t state_nxt;

  // Accumulate while the enable bit is set, hold otherwise
  always_comb begin
    state_nxt = state_r;
    if (ctl_if.wr) begin
      state_nxt.ctl = ctl_if.wdata;
    end
    if (acc_if.wr) begin
      state_nxt.acc = acc_if.wdata;
    end else if (state_r.ctl[UCB_LAT_EN_BIT] && lat_valid) begin
      state_nxt.acc = state_r.acc + {{(64-LAT_W){1'b0}}, lat_weight};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= {UCB_REG_RST, UCB_REG_RST};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Register views
  assign ctl_if.value = state_r.ctl;
  assign acc_if.value = state_r.acc;
  assign lat_en       = state_r.ctl[UCB_LAT_EN_BIT];

endmodule
`default_nettype wire

// [ucb_pkg.sv]
// Shared constants for the uncore event counter bank
package ucb_pkg;

  // Bank geometry
  localparam int UCB_NUM_REGS    = 8;
  localparam int UCB_NUM_EVT     = 6;
  localparam int UCB_HALF_W      = 32;
  localparam int UCB_QUAL_LSB    = 32;
  localparam int UCB_IDX_LAT_CTL = 6;
  localparam int UCB_IDX_LAT_ACC = 7;

  // Model register addresses
  localparam logic [31:0] UCB_ADDR_BUS_Q0  = 32'h0001_07CC;
  localparam logic [31:0] UCB_ADDR_BUS_Q1  = 32'h0001_07CD;
  localparam logic [31:0] UCB_ADDR_SNP_Q0  = 32'h0001_07CE;
  localparam logic [31:0] UCB_ADDR_SNP_Q1  = 32'h0001_07CF;
  localparam logic [31:0] UCB_ADDR_EXT_RD0 = 32'h0001_07D0;
  localparam logic [31:0] UCB_ADDR_EXT_RD1 = 32'h0001_07D1;
  localparam logic [31:0] UCB_ADDR_LAT_CTL = 32'h0001_07D2;
  localparam logic [31:0] UCB_ADDR_LAT_ACC = 32'h0001_07D3;

  // Counter read instruction index window
  localparam logic [31:0] UCB_CTR_IDX_FIRST = 32'h0000_0012;
  localparam logic [31:0] UCB_CTR_IDX_LAST  = 32'h0000_0019;

  // Latency control field and reset values
  localparam int          UCB_LAT_EN_BIT = 26;
  localparam logic [63:0] UCB_REG_RST    = 64'h0000_0000_0000_0000;

endpackage

// [ucb_reg_if.sv]
// Write strobe, write data and held value of one bank register
`timescale 1ns/100ps
`default_nettype none
interface ucb_reg_if;
  logic        wr;
  logic [63:0] wdata;
  logic [63:0] value;
  modport bank (input wr, input wdata, output value);
  modport host (output wr, output wdata, input value);
endinterface
`default_nettype wire
